// ==== hdl/cmsi_pkg.sv ====
// Package for the processor mode and fault indicator controller.
package cmsi_pkg;

    // AXI4-Lite register byte addresses.
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;

    // Control register fields (software commands, write one to act).
    localparam int CTRL_STOP_REQ   = 0;
    localparam int CTRL_SELF_STOP  = 1;
    localparam int CTRL_ORST_REQ   = 2;
    localparam int CTRL_INIT_DONE  = 3;
    localparam int CTRL_CHECK      = 4;

    // Event bits, shared by interrupt status and mask registers.
    localparam int EV_ACK_TIMEOUT  = 0;
    localparam int EV_ADDR_FAULT   = 1;
    localparam int EV_CYCLE_OVR    = 2;
    localparam int EV_MODE_CHANGE  = 3;
    localparam int EV_WIDTH        = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Flash timing at 250 MHz.
    localparam int CLK_MHZ          = 250;
    localparam int SLOW_HALF_MS     = 500;
    localparam int RAPID_HALF_MS    = 125;
    localparam int SLOW_HALF_CYC    = SLOW_HALF_MS * CLK_MHZ * 1000;
    localparam int RAPID_HALF_CYC   = RAPID_HALF_MS * CLK_MHZ * 1000;
    localparam int FLASH_W          = 27;

    // Momentary switch positions.
    typedef enum logic [1:0] {
        CMSI_MC_MID   = 2'b00,
        CMSI_MC_RESET = 2'b01,
        CMSI_MC_ORST  = 2'b10
    } cmsi_mc_t;

    typedef enum logic [2:0] {
        CMSI_ST_INIT   = 3'b000,
        CMSI_ST_RUN    = 3'b001,
        CMSI_ST_STOP   = 3'b010,
        CMSI_ST_SSTOP  = 3'b011,
        CMSI_ST_ORSTQ  = 3'b100,
        CMSI_ST_CHECK  = 3'b101
    } cmsi_state_t;

    // Fault inputs from the backplane access logic.
    typedef struct packed {
        logic ack_missing;
        logic module_present;
        logic addr_empty;
        logic cycle_overrun;
    } cmsi_fault_t;

    // Front panel indicators.
    typedef struct packed {
        logic run;
        logic stop;
        logic ack_timeout;
        logic address_fault;
        logic cycle_overrun;
        logic output_inhibit;
    } cmsi_led_t;

    // One-cycle memory actions toward the rest of the processor.
    typedef struct packed {
        logic erase_all_ram;
        logic clear_image;
        logic start_from_top;
        logic resume;
    } cmsi_action_t;

endpackage

// ==== hdl/cmsi_top.sv ====
// Operating mode sequencer and front panel indicator driver with AXI4-Lite registers.
// What this block does
// - In run, run indicator steady on, stop indicator off.
// - External stop request gives steady stop indicator, run off.
// - Initial start or program check: both run and stop dark.
// - Self-caused stop flashes slowly; mode switch to stop makes it steady.
// - Stop with overall reset pending flashes stop rapidly, run dark.
// - Present module failing to acknowledge lights acknowledge-timeout indicator.
// - Access to empty I/O address lights address-fault indicator.
// - Cycle exceeding maximum time lights cycle-overrun indicator.
// - Inhibited output lights inhibit indicator and forces outputs safe.
// - Power up with switch at stop requests overall reset, rapid flash, inhibit.
// - Overall-reset position plus stop-to-run performs overall reset, stop steady.
// - Reset position plus stop-to-run clears indicators and enters run.
// - Midpoint plus stop-to-run restarts, stop and inhibit off, run on.
// - Overall reset erases and initialises all RAM areas.
// - Reset clears flags, timers, counters, image; runs from start.
// - Restart resumes at interruption point, keeping all state.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cmsi_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  mode_switch_run,
    input  wire cmsi_pkg::cmsi_mc_t    momentary_switch,
    input  wire cmsi_pkg::cmsi_fault_t fault_in,
    output logic                       run_led,
    output logic                       stop_led,
    output logic                       ack_timeout_indicator,
    output logic                       address_fault_indicator,
    output logic                       cycle_overrun_indicator,
    output logic                       output_inhibit_indicator,
    output logic                       outputs_safe,
    output cmsi_pkg::cmsi_action_t     action,
    output logic                       irq,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    cmsi_pkg::cmsi_state_t state_reg;
    cmsi_pkg::cmsi_state_t state_next;
    logic                  mode_prev_reg;
    logic                  boot_reg;
    logic                  ext_stop_reg;
    logic                  inhibit_reg;
    logic [cmsi_pkg::FLASH_W-1:0] slow_cnt_reg;
    logic [cmsi_pkg::FLASH_W-1:0] rapid_cnt_reg;
    logic                  slow_ph_reg;
    logic                  rapid_ph_reg;
    logic [7:0]            aw_addr_reg;
    logic                  aw_have_reg;
    logic [31:0]           w_data_reg;
    logic [3:0]            w_strb_reg;
    logic                  w_have_reg;
    logic [cmsi_pkg::EV_WIDTH-1:0] irq_st_reg;
    logic [cmsi_pkg::EV_WIDTH-1:0] irq_msk_reg;
    logic [cmsi_pkg::EV_WIDTH-1:0] ev_set;
    logic [cmsi_pkg::EV_WIDTH-1:0] ev_clr;
    logic                  wr_fire;
    logic                  sw_cmd;
    logic                  up_edge;
    logic                  to_stop;

    // True when a full write lands on the given word with its low byte enabled.
    function automatic logic hit_low(input logic [7:0] a, input logic [3:0] s,
                                     input logic [7:0] reg_addr);
        hit_low = (a == reg_addr) && s[0];
    endfunction

    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign sw_cmd  = wr_fire && hit_low(aw_addr_reg, w_strb_reg, cmsi_pkg::ADDR_CTRL);
    assign up_edge = mode_switch_run && !mode_prev_reg;
    assign to_stop = !mode_switch_run && mode_prev_reg;

    // Mode sequencing from switches and software commands.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cmsi_pkg::CMSI_ST_INIT: begin
                if (boot_reg && !mode_switch_run) begin
                    state_next = cmsi_pkg::CMSI_ST_ORSTQ;
                end else if (boot_reg) begin
                    state_next = cmsi_pkg::CMSI_ST_RUN;
                end else if (sw_cmd && w_data_reg[cmsi_pkg::CTRL_CHECK]) begin
                    state_next = cmsi_pkg::CMSI_ST_CHECK;
                end
            end
            cmsi_pkg::CMSI_ST_CHECK: begin
                if (sw_cmd && w_data_reg[cmsi_pkg::CTRL_INIT_DONE]) begin
                    state_next = cmsi_pkg::CMSI_ST_RUN;
                end
            end
            cmsi_pkg::CMSI_ST_RUN: begin
                if (sw_cmd && w_data_reg[cmsi_pkg::CTRL_ORST_REQ]) begin
                    state_next = cmsi_pkg::CMSI_ST_ORSTQ;
                end else if (sw_cmd && w_data_reg[cmsi_pkg::CTRL_SELF_STOP]) begin
                    state_next = cmsi_pkg::CMSI_ST_SSTOP;
                end else if (to_stop || (sw_cmd && w_data_reg[cmsi_pkg::CTRL_STOP_REQ])) begin
                    state_next = cmsi_pkg::CMSI_ST_STOP;
                end
            end
            cmsi_pkg::CMSI_ST_SSTOP: begin
                if (to_stop) begin
                    state_next = cmsi_pkg::CMSI_ST_STOP;
                end else if (sw_cmd && w_data_reg[cmsi_pkg::CTRL_ORST_REQ]) begin
                    state_next = cmsi_pkg::CMSI_ST_ORSTQ;
                end
            end
            cmsi_pkg::CMSI_ST_STOP: begin
                if (sw_cmd && w_data_reg[cmsi_pkg::CTRL_ORST_REQ]) begin
                    state_next = cmsi_pkg::CMSI_ST_ORSTQ;
                end else if (up_edge && momentary_switch != cmsi_pkg::CMSI_MC_ORST) begin
                    state_next = cmsi_pkg::CMSI_ST_RUN;
                end
            end
            cmsi_pkg::CMSI_ST_ORSTQ: begin
                if (up_edge && momentary_switch == cmsi_pkg::CMSI_MC_ORST) begin
                    state_next = cmsi_pkg::CMSI_ST_STOP;
                end
            end
            default: state_next = cmsi_pkg::CMSI_ST_INIT;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= cmsi_pkg::CMSI_ST_INIT;
            mode_prev_reg <= 1'b0;
            boot_reg      <= 1'b1;
        end else begin
            state_reg     <= state_next;
            mode_prev_reg <= mode_switch_run;
            boot_reg      <= 1'b0;
        end
    end

    // Remembers whether the steady stop came from outside the processor.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_stop_reg <= 1'b0;
            inhibit_reg  <= 1'b1;
        end else begin
            ext_stop_reg <= (state_next == cmsi_pkg::CMSI_ST_STOP);
            inhibit_reg  <= (state_next != cmsi_pkg::CMSI_ST_RUN);
        end
    end

    // Memory actions issued on the transition that performs them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            action <= '0;
        end else begin
            action.erase_all_ram <= state_reg == cmsi_pkg::CMSI_ST_ORSTQ
                                    && state_next == cmsi_pkg::CMSI_ST_STOP;
            action.clear_image    <= state_reg == cmsi_pkg::CMSI_ST_STOP
                                     && state_next == cmsi_pkg::CMSI_ST_RUN
                                     && momentary_switch == cmsi_pkg::CMSI_MC_RESET;
            action.start_from_top <= state_reg == cmsi_pkg::CMSI_ST_STOP
                                     && state_next == cmsi_pkg::CMSI_ST_RUN
                                     && momentary_switch == cmsi_pkg::CMSI_MC_RESET;
            action.resume         <= state_reg == cmsi_pkg::CMSI_ST_STOP
                                     && state_next == cmsi_pkg::CMSI_ST_RUN
                                     && momentary_switch == cmsi_pkg::CMSI_MC_MID;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_cnt_reg  <= '0;
            rapid_cnt_reg <= '0;
            slow_ph_reg   <= 1'b0;
            rapid_ph_reg  <= 1'b0;
        end else begin
            if (slow_cnt_reg == cmsi_pkg::FLASH_W'(cmsi_pkg::SLOW_HALF_CYC - 1)) begin
                slow_cnt_reg <= '0;
                slow_ph_reg  <= !slow_ph_reg;
            end else begin
                slow_cnt_reg <= slow_cnt_reg + 1'b1;
            end
            if (rapid_cnt_reg == cmsi_pkg::FLASH_W'(cmsi_pkg::RAPID_HALF_CYC - 1)) begin
                rapid_cnt_reg <= '0;
                rapid_ph_reg  <= !rapid_ph_reg;
            end else begin
                rapid_cnt_reg <= rapid_cnt_reg + 1'b1;
            end
        end
    end

    // Indicator drive from the registered state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_led                  <= 1'b0;
            stop_led                 <= 1'b0;
            output_inhibit_indicator <= 1'b1;
            outputs_safe             <= 1'b1;
        end else begin
            run_led <= (state_reg == cmsi_pkg::CMSI_ST_RUN);
            case (state_reg)
                cmsi_pkg::CMSI_ST_STOP:  stop_led <= ext_stop_reg;
                cmsi_pkg::CMSI_ST_SSTOP: stop_led <= slow_ph_reg;
                cmsi_pkg::CMSI_ST_ORSTQ: stop_led <= rapid_ph_reg;
                default:                 stop_led <= 1'b0;
            endcase
            output_inhibit_indicator <= inhibit_reg;
            outputs_safe             <= inhibit_reg;
        end
    end

    // Fault indicators stay lit until the next reset or a reset-position stop-to-run entry (action.clear_image) clears them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_timeout_indicator   <= 1'b0;
            address_fault_indicator <= 1'b0;
            cycle_overrun_indicator <= 1'b0;
        end else begin
            if (action.clear_image) begin
                ack_timeout_indicator   <= 1'b0;
                address_fault_indicator <= 1'b0;
                cycle_overrun_indicator <= 1'b0;
            end
            if (fault_in.ack_missing && fault_in.module_present) begin
                ack_timeout_indicator <= 1'b1;
            end
            if (fault_in.addr_empty) begin
                address_fault_indicator <= 1'b1;
            end
            if (fault_in.cycle_overrun) begin
                cycle_overrun_indicator <= 1'b1;
            end
        end
    end

    always_comb begin
        ev_set = '0;
        ev_set[cmsi_pkg::EV_ACK_TIMEOUT] = fault_in.ack_missing && fault_in.module_present;
        ev_set[cmsi_pkg::EV_ADDR_FAULT]  = fault_in.addr_empty;
        ev_set[cmsi_pkg::EV_CYCLE_OVR]   = fault_in.cycle_overrun;
        ev_set[cmsi_pkg::EV_MODE_CHANGE] = (state_next != state_reg);
        ev_clr = '0;
        if (wr_fire && hit_low(aw_addr_reg, w_strb_reg, cmsi_pkg::ADDR_IRQ_ST)) begin
            ev_clr = w_data_reg[cmsi_pkg::EV_WIDTH-1:0];
        end
    end

    // Sticky events: a set in the clearing cycle wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_reg  <= '0;
            irq_msk_reg <= '0;
            irq         <= 1'b0;
        end else begin
            irq_st_reg <= (irq_st_reg & ~ev_clr) | ev_set;
            if (wr_fire && hit_low(aw_addr_reg, w_strb_reg, cmsi_pkg::ADDR_IRQ_MSK)) begin
                irq_msk_reg <= w_data_reg[cmsi_pkg::EV_WIDTH-1:0];
            end
            irq <= |(irq_st_reg & irq_msk_reg);
        end
    end

    // AXI4-Lite write side: address and data accepted in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cmsi_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_have_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_have_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == cmsi_pkg::ADDR_CTRL
                                 || aw_addr_reg == cmsi_pkg::ADDR_IRQ_ST
                                 || aw_addr_reg == cmsi_pkg::ADDR_IRQ_MSK)
                                ? cmsi_pkg::RESP_OKAY : cmsi_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side: one read at a time, answered the cycle after it is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= cmsi_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= cmsi_pkg::RESP_OKAY;
            case (s_axi_araddr)
                cmsi_pkg::ADDR_CTRL:    s_axi_rdata <= '0;
                cmsi_pkg::ADDR_STATUS:  s_axi_rdata <= {19'h0, ack_timeout_indicator,
                                            address_fault_indicator, cycle_overrun_indicator,
                                            output_inhibit_indicator, stop_led, run_led,
                                            mode_switch_run, 3'h0, state_reg};
                cmsi_pkg::ADDR_IRQ_ST:  s_axi_rdata <= {28'h0, irq_st_reg};
                cmsi_pkg::ADDR_IRQ_MSK: s_axi_rdata <= {28'h0, irq_msk_reg};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= cmsi_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ==== tb/cmsi_properties.sv ====
// Concurrent checks on the mode and fault indicator controller ports.
`timescale 1ns/10ps
`default_nettype none
module cmsi_properties (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire cmsi_pkg::cmsi_fault_t  fault_in,
    input wire logic                   run_led,
    input wire logic                   stop_led,
    input wire logic                   ack_timeout_indicator,
    input wire logic                   address_fault_indicator,
    input wire logic                   cycle_overrun_indicator,
    input wire logic                   output_inhibit_indicator,
    input wire logic                   outputs_safe,
    input wire cmsi_pkg::cmsi_action_t action,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [1:0]             s_axi_bresp
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_run_lit; run_led && !stop_led; endsequence
    sequence s_stop_lit; stop_led && !run_led; endsequence
    property p_run_dark; run_led |-> !stop_led && !output_inhibit_indicator; endproperty
    property p_safe; outputs_safe == output_inhibit_indicator; endproperty
    property p_ack; fault_in.ack_missing && fault_in.module_present |-> ##[1:3] ack_timeout_indicator; endproperty
    property p_addr; fault_in.addr_empty |-> ##[1:3] address_fault_indicator; endproperty
    property p_cyc; fault_in.cycle_overrun |-> ##[1:3] cycle_overrun_indicator; endproperty
    property p_erase; action.erase_all_ram |-> ##[0:2] s_stop_lit; endproperty
    property p_clear; action.clear_image |-> ##[0:2] s_run_lit; endproperty
    property p_resume; action.resume |-> ##[0:2] s_run_lit; endproperty
    property p_pulse; action != 4'h0 |=> action == 4'h0; endproperty
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_run_dark: assert property (p_run_dark)
        else $error("run lit beside stop or inhibit");
    a_safe: assert property (p_safe)
        else $error("safe outputs differ from inhibit");
    a_ack: assert property (p_ack)
        else $error("ack timeout not shown");
    a_addr: assert property (p_addr)
        else $error("address fault not shown");
    a_cyc: assert property (p_cyc)
        else $error("cycle overrun not shown");
    a_erase: assert property (p_erase)
        else $error("overall reset not ending in steady stop");
    a_clear: assert property (p_clear)
        else $error("reset not ending in run");
    a_resume: assert property (p_resume)
        else $error("restart not ending in run");
    a_pulse: assert property (p_pulse)
        else $error("action longer than one cycle");
    a_rd: assert property (p_rd)
        else $error("read answer late");
    a_bhold: assert property (p_bhold)
        else $error("write response dropped early");
endmodule
bind cmsi_top cmsi_properties u_props (.aclk(aclk), .aresetn(aresetn), .fault_in(fault_in),
    .run_led(run_led), .stop_led(stop_led), .ack_timeout_indicator(ack_timeout_indicator),
    .address_fault_indicator(address_fault_indicator), .action(action),
    .cycle_overrun_indicator(cycle_overrun_indicator), .outputs_safe(outputs_safe),
    .output_inhibit_indicator(output_inhibit_indicator), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));
`default_nettype wire

// ==== tb/cmsi_panel_model.sv ====
// Front panel switches and backplane fault sources driven on request.
`timescale 1ns/10ps
`default_nettype none
module cmsi_panel_model (
    input  wire logic            aclk,
    input  wire logic            want_run,
    input  wire logic [1:0]      want_mc,
    input  wire logic [3:0]      want_fault,
    output var logic             mode_switch_run,
    output cmsi_pkg::cmsi_mc_t   momentary_switch,
    output cmsi_pkg::cmsi_fault_t fault_in
);
    initial begin
        mode_switch_run = 1'b0;
        momentary_switch = cmsi_pkg::CMSI_MC_MID;
        fault_in = 4'h0;
    end
    // switch held first.
    // The mode switch only moves once the momentary switch has settled, as an operator would.
    always @(posedge aclk) begin
        momentary_switch <= cmsi_pkg::cmsi_mc_t'(want_mc);
        fault_in <= want_fault;
        if (momentary_switch == want_mc) begin
            mode_switch_run <= want_run;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the mode and fault indicator controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                   aclk = 1'b0;
    logic                   aresetn = 1'b0;
    logic                   want_run = 1'b0;
    logic [1:0]             want_mc = 2'h0;
    logic [3:0]             want_fault = 4'h0;
    logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]            wdata = 32'h0, rdata, d;
    logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                   arvalid = 1'b0, rready = 1'b0;
    logic                   awready, wready, bvalid, arready, rvalid, msr;
    logic [1:0]             bresp, rresp, r;
    logic                   run_led, stop_led, ack_i, addr_i, cyc_i, inh, safe, irq;
    cmsi_pkg::cmsi_mc_t     mc;
    cmsi_pkg::cmsi_fault_t  fault;
    cmsi_pkg::cmsi_action_t action;
    int                     mismatches = 0;
    int                     num_checks = 0;
    always #2 aclk = ~aclk;
    cmsi_panel_model panel_m (.aclk(aclk), .want_run(want_run), .want_mc(want_mc),
        .want_fault(want_fault), .mode_switch_run(msr), .momentary_switch(mc), .fault_in(fault));
    cmsi_top dut (.aclk(aclk), .aresetn(aresetn), .mode_switch_run(msr), .momentary_switch(mc),
        .fault_in(fault), .run_led(run_led), .stop_led(stop_led), .ack_timeout_indicator(ack_i),
        .address_fault_indicator(addr_i), .cycle_overrun_indicator(cyc_i), .irq(irq),
        .output_inhibit_indicator(inh), .outputs_safe(safe), .action(action),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) mismatches++;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) mismatches++;
    endtask
    // Switch changes take two model edges and two design edges; eight cycles leave margin.
    task automatic panel(input logic run, input logic [1:0] m, input logic [3:0] f);
        @(posedge aclk);
        want_run <= run;
        want_mc <= m;
        want_fault <= f;
        repeat (8) @(posedge aclk);
        #1;
    endtask
    task automatic t_modes;
        panel(1'b0, 2'h0, 4'h0);
        chk({run_led, stop_led, inh, safe}, 32'h3);
        rd(cmsi_pkg::ADDR_STATUS);
        chk(d[2:0], 32'h4);
        panel(1'b1, 2'h2, 4'h0);
        chk({run_led, stop_led, inh}, 32'h3);
        panel(1'b0, 2'h0, 4'h0);
        panel(1'b1, 2'h1, 4'h0);
        chk({run_led, stop_led, inh, safe}, 32'h8);
        $display("test modes done");
    endtask
    task automatic t_faults;
        wr(cmsi_pkg::ADDR_IRQ_MSK, 32'h7);
        panel(1'b1, 2'h1, 4'h8);
        chk({ack_i, irq}, 32'h0);
        panel(1'b1, 2'h1, 4'hF);
        panel(1'b1, 2'h1, 4'h0);
        chk({ack_i, addr_i, cyc_i, irq}, 32'hF);
        rd(cmsi_pkg::ADDR_IRQ_ST);
        chk(d[2:0], 32'h7);
        wr(cmsi_pkg::ADDR_IRQ_ST, 32'hF);
        rd(cmsi_pkg::ADDR_IRQ_ST);
        chk({irq, d[3:0]}, 32'h0);
        $display("test faults done");
    endtask
    task automatic t_stops;
        wr(cmsi_pkg::ADDR_CTRL, 32'h2);
        rd(cmsi_pkg::ADDR_STATUS);
        chk({run_led, inh, d[2:0]}, 32'hB);
        panel(1'b0, 2'h0, 4'h0);
        chk(stop_led, 32'h1);
        panel(1'b1, 2'h0, 4'h0);
        chk({run_led, stop_led, inh, ack_i, addr_i, cyc_i}, 32'h27);
        wr(cmsi_pkg::ADDR_CTRL, 32'h1);
        rd(cmsi_pkg::ADDR_STATUS);
        chk({run_led, stop_led, d[2:0]}, 32'h0A);
        panel(1'b0, 2'h0, 4'h0);
        panel(1'b1, 2'h1, 4'h0);
        chk({run_led, ack_i, addr_i, cyc_i}, 32'h8);
        wr(cmsi_pkg::ADDR_CTRL, 32'h4);
        rd(cmsi_pkg::ADDR_STATUS);
        chk({run_led, inh, d[2:0]}, 32'hC);
        $display("test stops done");
    endtask
    task automatic t_bus;
        rd(8'h10);
        chk({r, d[29:0]}, {2'h2, 30'h0});
        wr(8'h10, 32'h1);
        chk(r, cmsi_pkg::RESP_SLVERR);
        rd(cmsi_pkg::ADDR_CTRL);
        chk({r, d[29:0]}, 32'h0);
        $display("test bus done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_modes();
        t_faults();
        t_stops();
        t_bus();
        end_of_test();
    end
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
